// >>> design/ctrl_word_pkg.sv
// Shared constants and types for the converter control word link
package ctrl_word_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Word layout
    localparam int WORD_BITS = 32;
    localparam int HALF_BITS = 16;
    localparam int UPPER_BITS = 8;
    localparam int PAIRS = 3;
    localparam int REF_CODE_W = 10;
    localparam logic [31:0] CW_RESET = 32'h0000_03FF;
    // Pair fields start at pair A
    localparam int POS_PAIR_EN = 29;
    localparam int POS_RANGE = 26;
    localparam int POS_SRC_ON = 25;
    localparam int POS_BUF_DIS = 24;
    localparam int POS_SEQ = 23;
    localparam int POS_DOZE = 22;
    localparam int POS_DONE_FN = 21;
    localparam int POS_DONE_POL = 20;
    localparam int POS_UNUSED_HI = 19;
    localparam int POS_REF_3V = 18;
    localparam int POS_READBACK = 17;
    localparam int POS_FULL_UPD = 16;
    localparam int POS_PD = 13;
    localparam int POS_UNUSED_LO = 12;
    localparam int POS_TB_SRC = 11;
    localparam int POS_TB_OUT = 10;
    localparam logic [31:0] UNUSED_MASK = 32'h0008_1000;
    localparam logic [31:0] HW_IGNORE_MASK = 32'hFF80_0C00;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_MS = 10;
    localparam int SETTLE_CYCLES = SETTLE_MS * CLK_MHZ * 1000;
    localparam int HALF_CYCLES = 8;
    // Pin idle levels: cs_n, wr_n, sclk, fs_n high
    localparam logic [22:0] PIN_IDLE = 23'h1E_0000;

    ////////////////////////////////////////////////////////////////////////
    // Controller registers
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_READ = 8'h0C;
    localparam int CTRL_GO = 0;
    localparam int CTRL_SERIAL = 1;
    localparam int CTRL_SW_MODE = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_ACT = 3'b011,
        ST_REL = 3'b010,
        ST_END = 3'b110
    } host_state_t;

endpackage : ctrl_word_pkg

// >>> design/ctrl_word_link.sv
// Pin-level link between the converter control word and its controller
`timescale 1ns/1ps
interface ctrl_word_link;
    logic config_source_pin;
    logic interface_serial;
    logic cs_n;
    logic wr_n;
    logic [15:0] par_data;
    logic sclk;
    logic fs_n;
    logic sdi;
    logic serial_result_out;

    modport device (
        input config_source_pin,
        input interface_serial,
        input cs_n,
        input wr_n,
        input par_data,
        input sclk,
        input fs_n,
        input sdi,
        output serial_result_out
    );

    modport host (
        output config_source_pin,
        output interface_serial,
        output cs_n,
        output wr_n,
        output par_data,
        output sclk,
        output fs_n,
        output sdi,
        input serial_result_out
    );
endinterface : ctrl_word_link

// >>> design/adc_control_word_register.sv
// Converter control word: device end of the parallel/serial link
`timescale 1ns/1ps
module adc_control_word_register
    import ctrl_word_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to the controller
    ctrl_word_link.device link,
    // Conversion data for serial readout
    input wire logic [31:0] result_word,
    // Stored word
    output logic [31:0] control_word,
    // Decoded settings in force
    output logic [2:0] pair_enable,
    output logic [2:0] pair_range_double,
    output logic internal_source_on,
    output logic reference_buffer_disable,
    output logic interleaved_start_enable,
    output logic auto_doze_enable,
    output logic done_interrupt_mode,
    output logic done_polarity_invert,
    output logic reference_3v_select,
    output logic readback_enable,
    output logic full_word_update_enable,
    output logic [2:0] pair_power_down,
    output logic conversion_timebase_source,
    output logic timebase_output_enable,
    output logic [9:0] reference_level_code,
    output logic [2:0] pair_settled
);

    localparam int PW = 23;
    localparam int CW = $clog2(SETTLE_COUNT + 1);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire logic [PW-1:0] pin_raw = {
        link.config_source_pin,
        link.interface_serial,
        link.cs_n,
        link.wr_n,
        link.sclk,
        link.fs_n,
        link.sdi,
        link.par_data
    };
    logic [PW-1:0] sync1_reg;
    logic [PW-1:0] sync2_reg;
    logic [PW-1:0] prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= PIN_IDLE;
            sync2_reg <= PIN_IDLE;
            prev_reg <= PIN_IDLE;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    wire logic sw_mode = sync2_reg[22];
    wire logic ser_mode = sync2_reg[21];
    wire logic cs_n_s = sync2_reg[20];
    wire logic wr_n_s = sync2_reg[19];
    wire logic sclk_s = sync2_reg[18];
    wire logic fs_n_s = sync2_reg[17];
    wire logic sdi_s = sync2_reg[16];
    wire logic [15:0] data_s = sync2_reg[15:0];

    wire logic wr_rise = wr_n_s & ~prev_reg[19];
    wire logic sclk_fall = ~sclk_s & prev_reg[18];
    wire logic fs_fall = ~fs_n_s & prev_reg[17];

    ////////////////////////////////////////////////////////////////////////
    // Parallel path: upper half then lower half, one strobe each
    logic [31:0] word_reg;
    logic [31:0] word_next;
    logic [15:0] hold_reg;
    logic half_reg;

    wire logic par_strobe = ~ser_mode & ~cs_n_s & wr_rise;
    wire logic par_commit = par_strobe & half_reg;
    wire logic [31:0] par_word = {hold_reg, data_s};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= 16'h0000;
            half_reg <= 1'b0;
        end else if (cs_n_s) begin
            half_reg <= 1'b0;
        end else if (par_strobe) begin
            hold_reg <= data_s;
            half_reg <= ~half_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial path
    logic [4:0] bit_cnt_reg;
    logic [31:0] in_reg;
    logic [31:0] out_reg;

    wire logic ser_fall = ser_mode & ~fs_n_s & sclk_fall;
    wire logic [31:0] in_next = {in_reg[30:0], sdi_s};
    wire logic ser_commit = ser_fall & (bit_cnt_reg == 5'h1F);
    wire logic [31:0] ser_word = word_reg[POS_FULL_UPD] ?
        in_next : {in_next[31:24], word_reg[23:0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_reg <= 5'h00;
            in_reg <= 32'h0000_0000;
        end else if (fs_n_s) begin
            bit_cnt_reg <= 5'h00;
        end else if (ser_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            in_reg <= in_next;
        end
    end

    wire logic [31:0] out_load = word_reg[POS_READBACK] ? word_reg : result_word;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= 32'h0000_0000;
        end else if (ser_mode && fs_fall) begin
            out_reg <= out_load;
        end else if (ser_fall) begin
            out_reg <= {out_reg[30:0], 1'b0};
        end
    end

    assign link.serial_result_out = out_reg[31];

    ////////////////////////////////////////////////////////////////////////
    // Stored word
    // no change in hardware mode
    wire logic commit = sw_mode & (par_commit | ser_commit);
    wire logic [31:0] commit_word = ser_mode ? ser_word : par_word;

    always_comb begin
        word_next = word_reg;
        if (commit) begin
            word_next = commit_word & ~UNUSED_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= CW_RESET;
        end else begin
            word_reg <= word_next;
        end
    end

    assign control_word = word_reg;

    ////////////////////////////////////////////////////////////////////////
    // Settings in force
    // software-only fields drop out
    wire logic [31:0] eff = sw_mode ? word_reg : (word_reg & ~HW_IGNORE_MASK);

    assign pair_enable = eff[POS_PAIR_EN +: PAIRS];
    assign pair_range_double = eff[POS_RANGE +: PAIRS];
    assign internal_source_on = eff[POS_SRC_ON];
    assign reference_buffer_disable = eff[POS_BUF_DIS];
    assign interleaved_start_enable = eff[POS_SEQ];
    assign auto_doze_enable = eff[POS_DOZE];
    assign done_interrupt_mode = eff[POS_DONE_FN];
    assign done_polarity_invert = eff[POS_DONE_POL];
    assign reference_3v_select = eff[POS_REF_3V];
    assign readback_enable = eff[POS_READBACK];
    assign full_word_update_enable = eff[POS_FULL_UPD];
    assign pair_power_down = eff[POS_PD +: PAIRS];
    assign conversion_timebase_source = eff[POS_TB_SRC];
    assign timebase_output_enable = eff[POS_TB_OUT];
    assign reference_level_code = eff[REF_CODE_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Settling after power-down; the count restarts while the bit is set
    genvar gi;
    generate
        for (gi = 0; gi < PAIRS; gi++) begin : g_settle
            logic [CW-1:0] cnt_reg;
            logic ready_reg;
            wire logic pd = word_reg[POS_PD + gi];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_reg <= '0;
                    ready_reg <= 1'b1;
                end else if (pd) begin
                    cnt_reg <= CW'(SETTLE_COUNT);
                    ready_reg <= 1'b0;
                end else if (cnt_reg != '0) begin
                    cnt_reg <= cnt_reg - CW'(1);
                    ready_reg <= (cnt_reg == CW'(1));
                end
            end

            assign pair_settled[gi] = ready_reg;
        end
    endgenerate

endmodule : adc_control_word_register

// >>> design/ctrl_word_host.sv
// Controller end: APB registers driving the control word link
`timescale 1ns/1ps
module ctrl_word_host
    import ctrl_word_pkg::*;
#(
    parameter int PHASE_CYCLES = HALF_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the converter
    ctrl_word_link.host link
);

    ////////////////////////////////////////////////////////////////////////
    // Register access
    logic [31:0] cmd_reg;
    logic [31:0] read_reg;
    logic [31:0] rshift_reg;
    logic [31:0] shift_reg;
    logic [1:0] ctrl_reg;
    logic done_reg;
    logic [31:0] prdata_reg;
    logic [7:0] timer_reg;
    logic [4:0] idx_reg;
    logic sdo1_reg;
    logic sdo2_reg;
    host_state_t state_reg;

    wire logic busy = (state_reg != ST_IDLE);
    wire logic hit_cmd = (paddr == OFF_CMD);
    wire logic hit_ctrl = (paddr == OFF_CTRL);
    wire logic hit_stat = (paddr == OFF_STAT);
    wire logic hit_read = (paddr == OFF_READ);
    wire logic mapped = hit_cmd | hit_ctrl | hit_stat | hit_read;
    wire logic access = psel & penable;
    wire logic wr = access & pwrite & mapped;
    wire logic go = wr & hit_ctrl & pwdata[CTRL_GO] & ~busy;
    wire logic serial = ctrl_reg[CTRL_SERIAL - 1];
    wire logic sw_mode = ctrl_reg[CTRL_SW_MODE - 1];
    // Mode written together with GO governs the word it launches
    wire logic sw_now = go ? pwdata[CTRL_SW_MODE] : sw_mode;
    wire logic [31:0] stat_word = {30'h0, done_reg, busy};
    wire logic [31:0] rd_mux = hit_cmd ? cmd_reg :
        hit_ctrl ? {29'h0, ctrl_reg, 1'b0} :
        hit_stat ? stat_word :
        hit_read ? read_reg : 32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_reg;

    // Word as sent: host-side duties applied
    logic [31:0] send_word;
    always_comb begin
        send_word = cmd_reg;
        send_word[POS_UNUSED_HI] = 1'b0;
        send_word[POS_UNUSED_LO] = 1'b0;
        if (cmd_reg[POS_SEQ]) begin
            send_word[POS_TB_SRC] = 1'b1;
        end
        if (!sw_now) begin
            send_word[POS_TB_SRC] = 1'b0;
        end
        send_word[POS_PAIR_EN +: PAIRS] =
            cmd_reg[POS_PAIR_EN +: PAIRS] & ~cmd_reg[POS_PD +: PAIRS];
    end

    wire logic finish = (state_reg == ST_END) && (timer_reg == 8'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= CW_RESET;
            ctrl_reg <= CTRL_RESET;
            done_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            if (psel && !penable) begin
                prdata_reg <= rd_mux;
            end
            if (wr && hit_cmd) begin
                cmd_reg <= pwdata;
            end
            if (wr && hit_ctrl) begin
                ctrl_reg <= pwdata[CTRL_SW_MODE:CTRL_SERIAL];
            end
            // Completion wins over a same-cycle clear
            if (finish) begin
                done_reg <= 1'b1;
            end else if (wr && hit_stat && pwdata[STAT_DONE]) begin
                done_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer, each phase PHASE_CYCLES long
    wire logic tick = (timer_reg == 8'h00);
    wire logic last = serial ? (idx_reg == 5'h1F) : (idx_reg == 5'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo1_reg <= 1'b0;
            sdo2_reg <= 1'b0;
        end else begin
            sdo1_reg <= link.serial_result_out;
            sdo2_reg <= sdo1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            timer_reg <= 8'h00;
            idx_reg <= 5'h00;
            shift_reg <= 32'h0000_0000;
            rshift_reg <= 32'h0000_0000;
            read_reg <= 32'h0000_0000;
        end else begin
            timer_reg <= tick ? 8'(PHASE_CYCLES - 1) : timer_reg - 8'h01;
            case (state_reg)
                ST_IDLE: begin
                    timer_reg <= 8'(PHASE_CYCLES - 1);
                    if (go) begin
                        // device keeps what update mode allows
                        shift_reg <= send_word;
                        idx_reg <= 5'h00;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (tick) begin
                        state_reg <= ST_ACT;
                    end
                end
                ST_ACT: begin
                    if (tick) begin
                        rshift_reg <= {rshift_reg[30:0], sdo2_reg};
                        state_reg <= ST_REL;
                    end
                end
                ST_REL: begin
                    if (tick) begin
                        shift_reg <= serial ? {shift_reg[30:0], 1'b0} :
                            {shift_reg[15:0], 16'h0000};
                        idx_reg <= idx_reg + 5'h01;
                        state_reg <= last ? ST_END : ST_ACT;
                    end
                end
                ST_END: begin
                    if (tick) begin
                        if (serial) begin
                            read_reg <= rshift_reg;
                        end
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins
    wire logic framed = (state_reg == ST_SETUP) || (state_reg == ST_ACT) ||
        (state_reg == ST_REL);
    assign link.config_source_pin = sw_mode;
    assign link.interface_serial = serial;
    assign link.cs_n = ~(framed & ~serial);
    assign link.wr_n = ~((state_reg == ST_ACT) & ~serial);
    assign link.fs_n = ~(framed & serial);
    assign link.sclk = ~((state_reg == ST_REL) & serial);
    assign link.sdi = shift_reg[31];
    assign link.par_data = shift_reg[31:16];

endmodule : ctrl_word_host

// >>> tb/ctrl_word_link_assertions.sv
// Protocol checks on the control word link pins
`timescale 1ns/1ps
module ctrl_word_link_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link pins
    input wire logic config_source_pin,
    input wire logic interface_serial,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic [15:0] par_data,
    input wire logic sclk,
    input wire logic fs_n,
    input wire logic sdi,
    input wire logic serial_result_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // Parallel side
    property p_strobe_selected;
        !wr_n |-> !cs_n;
    endproperty
    a_strobe_selected: assert property (p_strobe_selected)
        else $error("store strobe low while not selected");
    property p_one_port;
        !cs_n |-> fs_n;
    endproperty
    a_one_port: assert property (p_one_port)
        else $error("select and frame low together");
    // Data may change as the strobe falls; it is latched on the rise
    property p_data_hold;
        (!wr_n && !$past(wr_n)) || $rose(wr_n) |-> $stable(par_data);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("parallel data moved under strobe");
    property p_strobe_width;
        $fell(wr_n) |-> !wr_n [*6];
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("store strobe too short");
    property p_select_to_strobe;
        $fell(cs_n) |-> ##[1:40] $fell(wr_n);
    endproperty
    a_select_to_strobe: assert property (p_select_to_strobe)
        else $error("no strobe after select");
    // Mode pins must not move mid-transfer, else the commit lands in the wrong mode
    property p_mode_steady;
        (!cs_n && !$past(cs_n)) || (!fs_n && !$past(fs_n))
            |-> $stable({interface_serial, config_source_pin});
    endproperty
    a_mode_steady: assert property (p_mode_steady)
        else $error("mode pins moved during transfer");

    ////////////////////////////////////////////////////////////////////////
    // Serial side
    property p_sclk_in_frame;
        $fell(sclk) |-> !fs_n;
    endproperty
    a_sclk_in_frame: assert property (p_sclk_in_frame)
        else $error("serial clock fell outside frame");
    // Data moves on the clock rise; the device samples on the fall
    property p_sdi_hold;
        !sclk && !fs_n |-> $stable(sdi);
    endproperty
    a_sdi_hold: assert property (p_sdi_hold)
        else $error("serial data moved while clock low");
    property p_sclk_low_width;
        $fell(sclk) |-> !sclk [*6];
    endproperty
    a_sclk_low_width: assert property (p_sclk_low_width)
        else $error("serial clock low phase too short");
endmodule : ctrl_word_link_assertions

// >>> tb/adc_control_word_register_tb_top.sv
// Self-checking bench: controller and converter control word joined by the link
`timescale 1ns/1ps
module adc_control_word_register_tb_top;
    import ctrl_word_pkg::*;
    localparam int P = 8;
    localparam int SETTLE = 20;
    localparam logic [31:0] RESULT = 32'hA5C3_1E69;
    localparam logic [31:0] W1 = 32'hF6D5_0EA5;
    localparam logic [31:0] W2 = 32'h2006_0155;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] result_word;
    logic [31:0] control_word;
    logic [2:0] pair_enable, pair_range_double, pair_power_down, pair_settled;
    logic internal_source_on, reference_buffer_disable, interleaved_start_enable;
    logic auto_doze_enable, done_interrupt_mode, done_polarity_invert;
    logic reference_3v_select, readback_enable, full_word_update_enable;
    logic conversion_timebase_source, timebase_output_enable;
    logic [9:0] reference_level_code;
    logic [31:0] rd;
    logic err_seen;
    int num_errors;
    int checks_done;
    wire logic [31:0] decoded;
    // Settings in force, laid back out in word order
    assign decoded = {pair_enable, pair_range_double, internal_source_on,
        reference_buffer_disable, interleaved_start_enable, auto_doze_enable,
        done_interrupt_mode, done_polarity_invert, 1'b0, reference_3v_select,
        readback_enable, full_word_update_enable, pair_power_down, 1'b0,
        conversion_timebase_source, timebase_output_enable, reference_level_code};

    ctrl_word_link ctrl_word_link_i ();
    ctrl_word_host #(.PHASE_CYCLES(P)) ctrl_word_host_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(ctrl_word_link_i));
    adc_control_word_register #(.SETTLE_COUNT(SETTLE)) adc_control_word_register_i (
        .pclk(pclk), .presetn(presetn), .link(ctrl_word_link_i),
        .result_word(result_word), .control_word(control_word),
        .pair_enable(pair_enable), .pair_range_double(pair_range_double),
        .internal_source_on(internal_source_on),
        .reference_buffer_disable(reference_buffer_disable),
        .interleaved_start_enable(interleaved_start_enable),
        .auto_doze_enable(auto_doze_enable), .done_interrupt_mode(done_interrupt_mode),
        .done_polarity_invert(done_polarity_invert),
        .reference_3v_select(reference_3v_select), .readback_enable(readback_enable),
        .full_word_update_enable(full_word_update_enable),
        .pair_power_down(pair_power_down),
        .conversion_timebase_source(conversion_timebase_source),
        .timebase_output_enable(timebase_output_enable),
        .reference_level_code(reference_level_code), .pair_settled(pair_settled));
    ctrl_word_link_assertions ctrl_word_link_assertions_i (
        .pclk(pclk), .presetn(presetn),
        .config_source_pin(ctrl_word_link_i.config_source_pin),
        .interface_serial(ctrl_word_link_i.interface_serial),
        .cs_n(ctrl_word_link_i.cs_n), .wr_n(ctrl_word_link_i.wr_n),
        .par_data(ctrl_word_link_i.par_data), .sclk(ctrl_word_link_i.sclk),
        .fs_n(ctrl_word_link_i.fs_n), .sdi(ctrl_word_link_i.sdi),
        .serial_result_out(ctrl_word_link_i.serial_result_out));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err_seen = pslverr;
        if (n >= 50) num_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Done is cleared up front so the caller sees outputs soon after commit
    task automatic send(input logic [31:0] w, input logic ser, input logic sw);
        int n;
        apb(1'b1, OFF_STAT, 32'h0000_0002);
        apb(1'b1, OFF_CMD, w);
        apb(1'b1, OFF_CTRL, {29'h0, sw, ser, 1'b1});
        n = 0;
        do begin
            apb(1'b0, OFF_STAT, 32'h0);
            n++;
        end while (rd[STAT_DONE] !== 1'b1 && n < 400);
        if (n >= 400) num_errors++;
    endtask : send

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        check("control_word", CW_RESET, control_word);
        check("decoded", CW_RESET, decoded);
        apb(1'b0, OFF_CMD, 32'h0);
        check("cmd reg", CW_RESET, rd);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped data", 32'h0, rd);
        check("unmapped error", 32'h1, {31'h0, err_seen});
        $display("test reset done");
    endtask : t_reset

    task automatic t_parallel;
        send(32'hE000_E3FF, 1'b0, 1'b1);
        check("decoded", 32'h0000_E3FF, decoded);
        check("settled", 32'h0, {29'h0, pair_settled});
        send((W1 | UNUSED_MASK) & ~32'h0000_0800, 1'b0, 1'b1);
        check("control_word", W1, control_word);
        check("decoded", W1, decoded);
        check("settled", 32'h0, {29'h0, pair_settled});
        repeat (SETTLE) @(posedge pclk);
        check("settled", 32'h7, {29'h0, pair_settled});
        $display("test parallel done");
    endtask : t_parallel

    task automatic t_hw_mode;
        send(32'h1111_0000, 1'b0, 1'b0);
        check("control_word", W1, control_word);
        check("decoded", W1 & ~HW_IGNORE_MASK, decoded);
        send(32'h1111_0000, 1'b1, 1'b0);
        check("control_word", W1, control_word);
        $display("test hardware mode done");
    endtask : t_hw_mode

    task automatic t_serial;
        send(W2, 1'b1, 1'b1);
        check("control_word", W2, control_word);
        check("decoded", W2, decoded);
        apb(1'b0, OFF_READ, 32'h0);
        check("shifted in", RESULT, rd);
        send(32'h4A00_0123, 1'b1, 1'b1);
        check("control_word", 32'h4A06_0155, control_word);
        apb(1'b0, OFF_READ, 32'h0);
        check("shifted in", W2, rd);
        $display("test serial done");
    endtask : t_serial

    ////////////////////////////////////////////////////////////////////////
    // Clock, main sequence, watchdog
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        result_word = RESULT;
        num_errors = 0;
        checks_done = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_parallel();
        t_hw_mode();
        t_serial();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("watchdog expired");
        summarize();
    end
endmodule : adc_control_word_register_tb_top
